// [core/pmr_top.sv]
// How it works
// - The fetched word is 14 bits split over the data high and data low registers.
// - The read location is the 12-bit address of address high and address low.
// - Address high bits beyond the implemented memory size are ignored.
// - Setting bit 0 of the read control register starts a read.
// - Software can only set the trigger bit; writing zero does nothing.
// - Hardware clears the trigger bit when the read is finished.
// - Each triggered read takes two cycles.
// - On completion the data pair is loaded with the word at the addressed location.
module pmr_top
    import pmr_pkg::*;
(
    input wire logic I_CORE_CLK, // Core clock
    input wire logic I_RST_N, // Synchronous reset, active low
    input wire logic I_PSEL, // APB select
    input wire logic I_PENABLE, // APB enable
    input wire logic I_PWRITE, // APB direction
    input wire logic [PMR_PAW-1:0] I_PADDR, // APB byte address
    input wire logic [PMR_DW-1:0] I_PWDATA, // APB write data
    input wire logic [3:0] I_PSTRB, // APB byte strobes
    output logic O_PREADY, // APB ready
    output logic [PMR_DW-1:0] O_PRDATA, // APB read data
    output logic O_PSLVERR, // APB error, unmapped address
    output logic O_BUSY, // Read in progress
    input wire logic I_PROG_WE, // Array programming strobe
    input wire logic [PMR_IMPL_AW-1:0] I_PROG_ADDR, // Array programming address
    input wire logic [PMR_WORD_W-1:0] I_PROG_DATA // Array programming word
);
    function automatic logic reg_hit(input logic [PMR_PAW-1:0] a);
        reg_hit = (a == PMR_OFF_CTRL) || (a == PMR_OFF_ADDR_LO) || (a == PMR_OFF_ADDR_HI)
            || (a == PMR_OFF_DATA_LO) || (a == PMR_OFF_DATA_HI);
    endfunction

    pmr_regs_t q;
    pmr_regs_t d;
    pmr_apb_req_t req;
    logic [PMR_WORD_W-1:0] mem_rdata;
    logic [PMR_ADDR_W-1:0] full_addr;
    logic [PMR_IMPL_AW-1:0] mem_addr;
    logic access;
    logic wr_take;
    logic [7:0] wbyte;
    logic [7:0] ctrl_view;

    assign req = '{sel: I_PSEL, enable: I_PENABLE, write: I_PWRITE, addr: I_PADDR,
                   wdata: I_PWDATA, strb: I_PSTRB};
    assign full_addr = {q.addr_hi, q.addr_lo};
    assign mem_addr = full_addr[PMR_IMPL_AW-1:0];
    assign access = req.sel && req.enable;
    assign wr_take = access && q.pready && req.write && req.strb[0] && reg_hit(req.addr);
    assign wbyte = req.wdata[7:0];
    assign ctrl_view = PMR_CTRL_FIXED | {7'b000_0000, q.rd};

    pmr_mem u_mem (
        .i_clk(I_CORE_CLK),
        .i_rd_en(q.state == PMR_FETCH),
        .i_rd_addr(mem_addr),
        .o_rd_data(mem_rdata),
        .i_wr_en(I_PROG_WE),
        .i_wr_addr(I_PROG_ADDR),
        .i_wr_data(I_PROG_DATA)
    );

    always_comb begin
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        // Answer one cycle into the access phase
        if (access && !q.pready) begin
            d.pready = 1'b1;
            d.pslverr = !reg_hit(req.addr);
            case (req.addr)
                PMR_OFF_CTRL: d.prdata = {24'h00_0000, ctrl_view};
                PMR_OFF_ADDR_LO: d.prdata = {24'h00_0000, q.addr_lo};
                PMR_OFF_ADDR_HI: d.prdata = {28'h000_0000, q.addr_hi};
                PMR_OFF_DATA_LO: d.prdata = {24'h00_0000, q.data_lo};
                PMR_OFF_DATA_HI: d.prdata = {26'h000_0000, q.data_hi};
                default: d.prdata = PMR_RST_RDATA;
            endcase
        end
        if (wr_take) begin
            case (req.addr)
                PMR_OFF_ADDR_LO: d.addr_lo = wbyte;
                PMR_OFF_ADDR_HI: d.addr_hi = wbyte[PMR_AHI_W-1:0];
                default: d.addr_lo = q.addr_lo;
            endcase
        end
        case (q.state)
            PMR_IDLE: begin
                // Only a one starts a read; zero and upper bits are dropped
                if (wr_take && req.addr == PMR_OFF_CTRL && wbyte[PMR_RD_BIT]) begin
                    d.rd = 1'b1;
                    d.state = PMR_FETCH;
                end
            end
            PMR_FETCH: begin
                d.state = PMR_LOAD;
            end
            PMR_LOAD: begin
                d.data_lo = mem_rdata[7:0];
                d.data_hi = mem_rdata[PMR_WORD_W-1:8];
                d.rd = 1'b0;
                d.state = PMR_IDLE;
            end
            default: begin
                d.rd = 1'b0;
                d.state = PMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            q <= '{state: PMR_IDLE, rd: 1'b0, addr_lo: 8'h00, addr_hi: 4'h0,
                   data_lo: 8'h00, data_hi: 6'h00, pready: 1'b0, pslverr: 1'b0,
                   prdata: PMR_RST_RDATA};
        end else begin
            q <= d;
        end
    end

    assign O_PREADY = q.pready;
    assign O_PRDATA = q.prdata;
    assign O_PSLVERR = q.pslverr;
    assign O_BUSY = q.rd;

    // Checks
    logic ctrl_set_take;
    logic ctrl_zero_take;
    logic ctrl_rd_ask;
    logic dhi_rd_ask;

    assign ctrl_set_take = wr_take && req.addr == PMR_OFF_CTRL && wbyte[PMR_RD_BIT];
    assign ctrl_zero_take = wr_take && req.addr == PMR_OFF_CTRL && !wbyte[PMR_RD_BIT];
    assign ctrl_rd_ask = access && !q.pready && !req.write && req.addr == PMR_OFF_CTRL;
    assign dhi_rd_ask = access && !q.pready && !req.write && req.addr == PMR_OFF_DATA_HI;

    sequence s_trigger;
        ctrl_set_take && q.state == PMR_IDLE;
    endsequence

    sequence s_fetch;
        q.rd && q.state == PMR_FETCH;
    endsequence

    sequence s_load;
        q.rd && q.state == PMR_LOAD;
    endsequence

    property p_read_flow;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        s_trigger |=> s_fetch ##1 s_load ##1 (!q.rd && q.state == PMR_IDLE);
    endproperty

    a_read_flow_order: assert property (p_read_flow)
        else $error("read did not step through fetch and load");

    a_rd_two_cycles: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        $rose(q.rd) |-> q.rd [*2] ##1 !q.rd)
        else $error("trigger bit not high for exactly two cycles");

    a_rd_self_clear: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        q.rd |-> ##[1:2] !q.rd)
        else $error("trigger bit not cleared by hardware");

    // Control writes are ignored outside idle, so during a read only completion may drop the bit
    a_zero_no_clear: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (q.rd && q.state != PMR_LOAD) |=> q.rd)
        else $error("trigger bit dropped before the read completed");

    a_zero_no_start: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (ctrl_zero_take && q.state == PMR_IDLE) |=> !q.rd)
        else $error("zero write started a read");

    a_load_word: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        q.state == PMR_LOAD |=> {q.data_hi, q.data_lo} == $past(mem_rdata))
        else $error("data pair not loaded with fetched word");

    a_fetch_addr_used: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        q.state == PMR_FETCH |-> mem_addr == {q.addr_hi[PMR_IMPL_AW-9:0], q.addr_lo})
        else $error("fetch address does not follow address pair");

    a_data_high_width: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        dhi_rd_ask |=> O_PREADY && O_PRDATA[PMR_DW-1:PMR_DHI_W] == '0)
        else $error("data high returned bits above the word");

    a_ctrl_fixed_bits: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        ctrl_rd_ask |=> O_PRDATA[PMR_DW-1:1] == 31'h0000_0040)
        else $error("control register fixed bits wrong");

    a_apb_one_wait: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (access && !q.pready) |=> O_PREADY ##1 !O_PREADY)
        else $error("ready not a single pulse one cycle into access");

    a_unmapped_error: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (access && !q.pready && !reg_hit(req.addr)) |=> O_PSLVERR)
        else $error("unmapped address gave no error");

    a_idle_no_start: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (q.state == PMR_IDLE && !ctrl_set_take) |=> (q.state == PMR_IDLE && !q.rd))
        else $error("read started without a trigger write");

    a_addr_hold: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        !wr_take |=> ($stable(q.addr_lo) && $stable(q.addr_hi)))
        else $error("address pair changed without a taken write");

    a_data_hold: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        q.state != PMR_LOAD |=> $stable({q.data_hi, q.data_lo}))
        else $error("data pair changed outside read completion");
endmodule // pmr_top

// [core/pmr_pkg.sv]
package pmr_pkg;
    localparam int PMR_PAW = 12;
    localparam int PMR_DW = 32;
    localparam int PMR_WORD_W = 14;
    localparam int PMR_ADDR_W = 12;
    localparam int PMR_IMPL_AW = 11;
    localparam int PMR_DEPTH = 2 ** PMR_IMPL_AW;
    localparam int PMR_DHI_W = PMR_WORD_W - 8;
    localparam int PMR_AHI_W = PMR_ADDR_W - 8;
    localparam logic [PMR_PAW-1:0] PMR_OFF_CTRL = 12'h018C;
    localparam logic [PMR_PAW-1:0] PMR_OFF_ADDR_LO = 12'h0190;
    localparam logic [PMR_PAW-1:0] PMR_OFF_ADDR_HI = 12'h0194;
    localparam logic [PMR_PAW-1:0] PMR_OFF_DATA_LO = 12'h0198;
    localparam logic [PMR_PAW-1:0] PMR_OFF_DATA_HI = 12'h019C;
    localparam int PMR_RD_BIT = 0;
    localparam int PMR_RSVD_BIT = 7;
    localparam logic [7:0] PMR_CTRL_FIXED = 8'h80;
    localparam logic [PMR_DW-1:0] PMR_RST_RDATA = 32'h0000_0000;
    localparam int PMR_READ_CYCLES = 2;

    typedef enum logic [2:0] {
        PMR_IDLE = 3'b001,
        PMR_FETCH = 3'b010,
        PMR_LOAD = 3'b100
    } pmr_state_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [PMR_PAW-1:0] addr;
        logic [PMR_DW-1:0] wdata;
        logic [3:0] strb;
    } pmr_apb_req_t;

    typedef struct packed {
        pmr_state_t state;
        logic rd;
        logic [7:0] addr_lo;
        logic [PMR_AHI_W-1:0] addr_hi;
        logic [7:0] data_lo;
        logic [PMR_DHI_W-1:0] data_hi;
        logic pready;
        logic pslverr;
        logic [PMR_DW-1:0] prdata;
    } pmr_regs_t;
endpackage : pmr_pkg

// [core/pmr_mem.sv]
module pmr_mem
    import pmr_pkg::*;
(
    input wire logic i_clk, // Core clock
    input wire logic i_rd_en, // Read strobe
    input wire logic [PMR_IMPL_AW-1:0] i_rd_addr, // Read word address
    output logic [PMR_WORD_W-1:0] o_rd_data, // Registered read word
    input wire logic i_wr_en, // Programming strobe
    input wire logic [PMR_IMPL_AW-1:0] i_wr_addr, // Programming address
    input wire logic [PMR_WORD_W-1:0] i_wr_data // Programming word
);
    logic [PMR_WORD_W-1:0] mem [PMR_DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        if (i_rd_en) begin
            o_rd_data <= mem[i_rd_addr];
        end
    end
endmodule // pmr_mem

// [tb/pmr_array_model.sv]
module pmr_array_model
    import pmr_pkg::*;
(
    input wire logic i_clk, // Core clock
    output logic o_we, // Programming strobe
    output logic [PMR_IMPL_AW-1:0] o_addr, // Word address
    output logic [PMR_WORD_W-1:0] o_data // Programmed word
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [PMR_WORD_W-1:0] shadow [PMR_DEPTH];

    initial begin
        o_we = 1'b0;
        o_addr = '0;
        o_data = '0;
    end

    // Burns one word and keeps a copy for the bench's expectations
    task automatic burn(input logic [PMR_IMPL_AW-1:0] a, input logic [PMR_WORD_W-1:0] d);
        @(posedge i_clk);
        o_we <= 1'b1;
        o_addr <= a;
        o_data <= d;
        shadow[a] = d;
        @(posedge i_clk);
        o_we <= 1'b0;
        o_addr <= ~a;
        o_data <= ~d;
    endtask
endmodule // pmr_array_model

// [tb/pmr_program_memory_read_port_tb.sv]
module pmr_program_memory_read_port_tb
    import pmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, busy, we, err;
    logic [PMR_PAW-1:0] paddr;
    logic [PMR_DW-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb, strb_v;
    logic [PMR_IMPL_AW-1:0] wa;
    logic [PMR_WORD_W-1:0] wd;
    int bad_count, samples_checked, cycles;

    pmr_top u_dut (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
        .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr), .O_BUSY(busy),
        .I_PROG_WE(we), .I_PROG_ADDR(wa), .I_PROG_DATA(wd)
    );

    pmr_array_model u_mem (.i_clk(clk), .o_we(we), .o_addr(wa), .o_data(wd));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Expected read-back of one half of a program word
    function automatic logic [31:0] exp_half(input logic [PMR_WORD_W-1:0] word, input bit high);
        exp_half = high ? {26'h000_0000, word[PMR_WORD_W-1:8]} : {24'h00_0000, word[7:0]};
    endfunction

    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wdat,
                       output logic [31:0] rdat, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wdat;
        pstrb <= strb_v;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) chk(32'h0000_0000, 32'h0000_0001);
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        logic [7:0] lo;
        logic [3:0] hi;
        logic [13:0] w;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        strb_v = 4'hF;
        void'($urandom(52));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, PMR_OFF_CTRL, '0, rd, err);
        chk(rd, 32'h0000_0080);
        apb(1'b1, PMR_OFF_CTRL, 32'hFFFF_FFFE, rd, err);
        apb(1'b0, PMR_OFF_CTRL, '0, rd, err);
        chk(rd, 32'h0000_0080);
        chk(32'(busy), 32'h0000_0000);
        apb(1'b0, 12'h0FF0, '0, rd, err);
        chk(32'(err), 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 24; i++) begin
            lo = (i == 0) ? 8'hFF : 8'($urandom);
            hi = (i == 0) ? 4'hF : 4'($urandom);
            w = 14'($urandom);
            u_mem.burn({hi[2:0], lo}, w);
            apb(1'b1, PMR_OFF_ADDR_LO, {24'h00_0000, lo}, rd, err);
            apb(1'b1, PMR_OFF_ADDR_HI, ($urandom & 32'hFFFF_FFF0) | {28'h000_0000, hi}, rd, err);
            // A write with byte lane 0 off must be dropped
            strb_v = 4'hE;
            apb(1'b1, PMR_OFF_ADDR_LO, {24'h00_0000, ~lo}, rd, err);
            strb_v = 4'hF;
            apb(1'b0, PMR_OFF_ADDR_LO, '0, rd, err);
            chk(rd, {24'h00_0000, lo});
            chk(32'(err), 32'h0000_0000);
            apb(1'b0, PMR_OFF_ADDR_HI, '0, rd, err);
            chk(rd, {28'h000_0000, hi});
            apb(1'b1, PMR_OFF_CTRL, $urandom | 32'h0000_0001, rd, err);
            #1 chk(32'(busy), 32'h0000_0001);
            @(posedge clk);
            #1 chk(32'(busy), 32'h0000_0001);
            @(posedge clk);
            #1 chk(32'(busy), 32'h0000_0000);
            apb(1'b1, PMR_OFF_DATA_LO, $urandom, rd, err);
            apb(1'b0, PMR_OFF_DATA_LO, '0, rd, err);
            chk(rd, exp_half(u_mem.shadow[{hi[2:0], lo}], 1'b0));
            apb(1'b0, PMR_OFF_DATA_HI, '0, rd, err);
            chk(rd, exp_half(w, 1'b1));
            apb(1'b0, PMR_OFF_CTRL, '0, rd, err);
            chk(rd, 32'h0000_0080);
        end
        end_sim();
    end
endmodule // pmr_program_memory_read_port_tb
